// ---- shared/frame_seq_pkg.sv ----
// Constants shared by the frame sequencer and its serial word sender.
// Assumes a 40 MHz system clock and a separate free-running buffer shift clock.
package frame_seq_pkg;
	localparam int SETTLE_COUNT  = 128;
	localparam int FRAME_SAMPLES = 1708;
	localparam int SETTLE_W      = 8;
	localparam int COUNT_W       = 11;
	localparam int SAMPLE_W      = 8;
	localparam int HK_W          = 7;
	localparam int WORD_W        = 10;
	localparam int SYNC_POS      = 9;
	localparam int GAIN_POS      = 8;
	localparam logic SYNC_LEVEL  = 1'b1;
	localparam logic [7:0] SIGN_FLIP = 8'h80;
	localparam logic [3:0] SHIFT_COUNT = 4'ha;
	localparam int STEP_W        = 3;
	localparam logic [2:0] STEP_MAX = 3'h4;
	localparam int HK_CHAN_W     = 4;
	localparam int RAMP_W        = 13;
	localparam int DRIVE_W       = 24;
	localparam int SERVO_POS_WEIGHT = 342;
	localparam int SERVO_NEG_WEIGHT = 400;
	localparam int PIN_START = 0;
	localparam int PIN_400   = 1;
	localparam int PIN_NEON  = 2;
	localparam int PIN_GHI   = 3;
	localparam int PIN_GLO   = 4;
	localparam int PIN_MATCH = 5;
	localparam int PIN_HKM   = 6;
	localparam int PIN_ACK   = 7;
	localparam int PIN_N     = 8;
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SETTLE = 2'b01,
		ST_SAMPLE = 2'b11,
		ST_FINISH = 2'b10
	} frame_state_t;
endpackage

// ---- verilog/word_sender.sv ----
// Serial word sender on the buffer shift clock: one 10-bit word per request toggle.
// Assumes the word input is held stable from a request toggle until the ack toggle returns.
`timescale 1ns/10ps
module word_sender (
	// Shift clock domain
	input  wire logic                              link_clk,
	input  wire logic                              rst_n,
	// Request from the system clock domain
	input  wire logic [frame_seq_pkg::WORD_W-1:0] word,
	input  wire logic                              req_tgl,
	output logic                                   ack_tgl,
	// Buffer side
	output logic                                   buf_data,
	output logic                                   buf_gate
);
	logic                             rst_s1_reg;
	logic                             rst_s2_reg;
	logic                             link_rst_n;
	logic [2:0]                       req_s_reg;
	logic                             req_f_reg;
	logic                             req_seen_reg;
	logic [frame_seq_pkg::WORD_W-1:0] shift_reg;
	logic [3:0]                       bit_cnt_reg;
	logic                             gate_reg;
	logic                             data_reg;
	logic                             ack_reg;
	logic [3:0]                       gate_len_reg;
	logic                             req_f_next;
	logic                             load;
	logic                             last_bit;

	assign link_rst_n = rst_s2_reg;
	assign req_f_next = (req_s_reg[1] == req_s_reg[2]) ? req_s_reg[1] : req_f_reg;
	assign load       = !gate_reg && (req_f_reg != req_seen_reg);
	assign last_bit   = gate_reg && (bit_cnt_reg == frame_seq_pkg::SHIFT_COUNT);
	assign ack_tgl    = ack_reg;
	assign buf_data   = data_reg;
	assign buf_gate   = gate_reg;

	// The reset is synchronised into this domain so it is released on a shift clock edge.
	always_ff @(posedge link_clk) begin
		rst_s1_reg <= rst_n;
		rst_s2_reg <= rst_s1_reg;
	end

	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			req_s_reg    <= 3'h0;
			req_f_reg    <= 1'b0;
			req_seen_reg <= 1'b0;
			shift_reg    <= '0;
			bit_cnt_reg  <= 4'h0;
			gate_reg     <= 1'b0;
			data_reg     <= 1'b0;
			ack_reg      <= 1'b0;
		end else begin
			req_s_reg <= {req_s_reg[1:0], req_tgl};
			req_f_reg <= req_f_next;
			if (load) begin
				req_seen_reg <= req_f_reg;
				gate_reg     <= 1'b1;
				data_reg     <= word[frame_seq_pkg::WORD_W-1];
				shift_reg    <= {word[frame_seq_pkg::WORD_W-2:0], 1'b0};
				bit_cnt_reg  <= 4'h1;
			end else if (last_bit) begin
				gate_reg <= 1'b0;
				data_reg <= 1'b0;
				ack_reg  <= ~ack_reg;
			end else if (gate_reg) begin
				data_reg    <= shift_reg[frame_seq_pkg::WORD_W-1];
				shift_reg   <= {shift_reg[frame_seq_pkg::WORD_W-2:0], 1'b0};
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
		end
	end

	// Checker helper: counts how long the gate has stood high, independent of the bit counter.
	always_ff @(posedge link_clk) begin
		if (!link_rst_n)
			gate_len_reg <= 4'h0;
		else
			gate_len_reg <= gate_reg ? gate_len_reg + 4'h1 : 4'h0;
	end

	default clocking cb_link @(posedge link_clk); endclocking
	default disable iff (!link_rst_n);

	property p_gate_ten;
		$fell(gate_reg) |-> gate_len_reg == frame_seq_pkg::SHIFT_COUNT;
	endproperty
	a_gate_ten: assert property (p_gate_ten) else $error("gate not open for ten shifts");

	property p_gate_max;
		gate_reg |-> gate_len_reg < frame_seq_pkg::SHIFT_COUNT;
	endproperty
	a_gate_max: assert property (p_gate_max) else $error("gate open past ten shifts");

	property p_sync_first;
		$rose(gate_reg) |-> data_reg == frame_seq_pkg::SYNC_LEVEL;
	endproperty
	a_sync_first: assert property (p_sync_first) else $error("first bit is not sync");

	property p_gate_word;
		$rose(gate_reg) |-> ##10 (ack_reg != $past(ack_reg, 10));
	endproperty
	c_gate_word: cover property (p_gate_word);
endmodule // word_sender

// ---- verilog/frame_sequencer.sv ----
// Interferogram frame sequencer: frame timing, ramp converters, gain flag, servo ramps, word output.
// Assumes analog comparators and DACs outside; all pin inputs are asynchronous to SYS_CLK.
// Function
// - One start command; device runs the rest.
// - Attenuate above 3.2 V, release below 0.32 V.
// - Hold encodes 128 counts, then pass 171 cps.
// - Count encode pulses; exactly 1708 per frame.
// - After last sample, drive off, await start.
// - Encode starts up-ramp; stop at match gives sample.
// - Word: sample low, gain ninth, sync tenth.
// - Gate shift clock for exactly ten bits.
// - Separate 7-bit converter samples housekeeping channels.
// - Start selects high rate; frame end selects low.
// - 400 cps steps commutator and encodes housekeeping.
// - Servo: 400 cps up-ramp minus neon down-ramp.
// - Drive zero at nominal rate whole frame.
// - Frame end gates off and clears ramps.
// - Ninth bit marks divide-by-ten path.
// - Sample is signed, 256 levels around zero.
`timescale 1ns/10ps
module frame_sequencer #(
	parameter int SETTLE_COUNT  = frame_seq_pkg::SETTLE_COUNT,
	parameter int FRAME_SAMPLES = frame_seq_pkg::FRAME_SAMPLES
) (
	// System clock and reset
	input  wire logic                                  SYS_CLK,
	input  wire logic                                  RST_N,
	// Buffer shift clock
	input  wire logic                                  LINK_CLK,
	// Spacecraft and reference inputs
	input  wire logic                                  FRAME_START,
	input  wire logic                                  SC_CLK_400,
	input  wire logic                                  NEON_REF,
	// Gain comparator and converter comparators
	input  wire logic                                  GAIN_ABOVE_HI,
	input  wire logic                                  GAIN_BELOW_LO,
	input  wire logic                                  RAMP_MATCH,
	input  wire logic                                  HK_MATCH,
	// Interferogram converter
	output logic                                       GAIN_ATTEN,
	output logic                                       ENCODE,
	output logic [frame_seq_pkg::SAMPLE_W-1:0]         RAMP_CODE,
	// Housekeeping converter and commutator
	output logic                                       HK_ENCODE,
	output logic [frame_seq_pkg::HK_W-1:0]             HK_RAMP_CODE,
	output logic [frame_seq_pkg::HK_CHAN_W-1:0]        HK_CHAN,
	// Frame status and mirror drive
	output logic                                       HIGH_RATE_SEL,
	output logic                                       END_OF_FRAME,
	output logic                                       MIRROR_EN,
	output logic signed [frame_seq_pkg::DRIVE_W-1:0]   MIRROR_DRIVE,
	// Spacecraft buffer
	output logic                                       BUF_DATA,
	output logic                                       BUF_GATE
);
	localparam int PN = frame_seq_pkg::PIN_N;

	frame_seq_pkg::frame_state_t               state_reg;
	frame_seq_pkg::frame_state_t               state_next;
	logic [PN-1:0]                             pins;
	logic [PN-1:0]                             s1_reg;
	logic [PN-1:0]                             s2_reg;
	logic [PN-1:0]                             s3_reg;
	logic [PN-1:0]                             filt_reg;
	logic [PN-1:0]                             filt_next;
	logic [PN-1:0]                             prev_reg;
	logic [PN-1:0]                             rise;
	logic                                      ack_link;
	logic                                      start_rise;
	logic                                      clk400_rise;
	logic                                      neon_rise;
	logic                                      gain_hi;
	logic                                      gain_lo;
	logic                                      gain_reg;
	logic                                      gain_next;
	logic                                      sq_reg;
	logic                                      sq_rise;
	logic [frame_seq_pkg::SETTLE_W-1:0]        settle_cnt_reg;
	logic [frame_seq_pkg::COUNT_W-1:0]         enc_cnt_reg;
	logic                                      settle_done;
	logic                                      encode;
	logic                                      encode_reg;
	logic                                      conv_busy_reg;
	logic [frame_seq_pkg::SAMPLE_W-1:0]        ramp_reg;
	logic [frame_seq_pkg::STEP_W-1:0]          step_reg;
	logic                                      tick;
	logic                                      hr_eoc;
	logic                                      hk_busy_reg;
	logic [frame_seq_pkg::HK_W-1:0]            hk_ramp_reg;
	logic [frame_seq_pkg::STEP_W-1:0]          hk_step_reg;
	logic                                      hk_tick;
	logic                                      hk_eoc;
	logic                                      hk_enc_reg;
	logic [frame_seq_pkg::HK_CHAN_W-1:0]       hk_chan_reg;
	logic [frame_seq_pkg::SAMPLE_W-1:0]        sample_signed;
	logic [frame_seq_pkg::WORD_W-1:0]          hr_word;
	logic [frame_seq_pkg::WORD_W-1:0]          hk_word;
	logic [frame_seq_pkg::WORD_W-1:0]          word_reg;
	logic                                      req_reg;
	logic                                      link_busy;
	logic                                      send_hr;
	logic                                      send_hk;
	logic                                      high_rate_reg;
	logic                                      eof_reg;
	logic                                      mirror_en_reg;
	logic                                      servo_gate;
	logic [frame_seq_pkg::RAMP_W-1:0]          pos_reg;
	logic [frame_seq_pkg::RAMP_W-1:0]          neg_reg;
	logic [frame_seq_pkg::DRIVE_W-1:0]         pos_term;
	logic [frame_seq_pkg::DRIVE_W-1:0]         neg_term;
	logic signed [frame_seq_pkg::DRIVE_W-1:0]  drive_reg;

	// Shared by both ramp converters: each ramp step lasts five cycles, so the synchronised
	// comparator level of the current code has settled before the step's last cycle.
	function automatic logic [frame_seq_pkg::STEP_W-1:0] step_next(
		input logic [frame_seq_pkg::STEP_W-1:0] cnt,
		input logic                             restart
	);
		if (restart || cnt == frame_seq_pkg::STEP_MAX)
			return '0;
		return cnt + 1'b1;
	endfunction

	// Input conditioning: three flops, a level rises once stages two and three agree high and falls as soon as they differ.
	assign pins = {ack_link, HK_MATCH, RAMP_MATCH, GAIN_BELOW_LO, GAIN_ABOVE_HI, NEON_REF, SC_CLK_400, FRAME_START};
	assign filt_next   = (s2_reg & s3_reg) | (filt_reg & ~(s2_reg ^ s3_reg));
	assign rise        = filt_reg & ~prev_reg;
	assign start_rise  = rise[frame_seq_pkg::PIN_START];
	assign clk400_rise = rise[frame_seq_pkg::PIN_400];
	assign neon_rise   = rise[frame_seq_pkg::PIN_NEON];
	assign gain_hi     = filt_reg[frame_seq_pkg::PIN_GHI];
	assign gain_lo     = filt_reg[frame_seq_pkg::PIN_GLO];

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			s1_reg   <= '0;
			s2_reg   <= '0;
			s3_reg   <= '0;
			filt_reg <= '0;
			prev_reg <= '0;
		end else begin
			s1_reg   <= pins;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			filt_reg <= filt_next;
			prev_reg <= filt_reg;
		end
	end

	// Hysteresis: the high threshold wins if both comparators claim at once.
	assign gain_next = gain_hi ? 1'b1 : (gain_lo ? 1'b0 : gain_reg);

	// The 171 cps square wave is the neon reference divided by two.
	assign sq_rise     = neon_rise && !sq_reg;
	assign settle_done = sq_rise && (settle_cnt_reg == frame_seq_pkg::SETTLE_W'(SETTLE_COUNT - 1));
	assign encode      = (state_reg == frame_seq_pkg::ST_SAMPLE) && sq_rise
		&& (enc_cnt_reg < frame_seq_pkg::COUNT_W'(FRAME_SAMPLES));

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			frame_seq_pkg::ST_IDLE: begin
				if (start_rise)
					state_next = frame_seq_pkg::ST_SETTLE;
			end
			frame_seq_pkg::ST_SETTLE: begin
				if (settle_done)
					state_next = frame_seq_pkg::ST_SAMPLE;
			end
			frame_seq_pkg::ST_SAMPLE: begin
				if (enc_cnt_reg == frame_seq_pkg::COUNT_W'(FRAME_SAMPLES) && !conv_busy_reg && !encode_reg)
					state_next = frame_seq_pkg::ST_FINISH;
			end
			default: begin
				state_next = frame_seq_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			state_reg      <= frame_seq_pkg::ST_IDLE;
			gain_reg       <= 1'b0;
			sq_reg         <= 1'b0;
			settle_cnt_reg <= '0;
			enc_cnt_reg    <= '0;
			encode_reg     <= 1'b0;
			high_rate_reg  <= 1'b0;
			eof_reg        <= 1'b0;
			mirror_en_reg  <= 1'b0;
		end else begin
			state_reg     <= state_next;
			gain_reg      <= gain_next;
			sq_reg        <= neon_rise ? ~sq_reg : sq_reg;
			encode_reg    <= encode;
			eof_reg       <= (state_reg == frame_seq_pkg::ST_FINISH);
			mirror_en_reg <= (state_next == frame_seq_pkg::ST_SETTLE) || (state_next == frame_seq_pkg::ST_SAMPLE);
			if (state_reg == frame_seq_pkg::ST_IDLE) begin
				settle_cnt_reg <= '0;
				enc_cnt_reg    <= '0;
			end else begin
				if (state_reg == frame_seq_pkg::ST_SETTLE && sq_rise)
					settle_cnt_reg <= settle_cnt_reg + 1'b1;
				if (encode)
					enc_cnt_reg <= enc_cnt_reg + 1'b1;
			end
			if (state_reg == frame_seq_pkg::ST_IDLE && start_rise)
				high_rate_reg <= 1'b1;
			else if (state_reg == frame_seq_pkg::ST_FINISH)
				high_rate_reg <= 1'b0;
		end
	end

	// Ramp converters. A match is only trusted on a step tick, which lies past the input
	// synchroniser delay, so a stale comparator level from the last ramp cannot end a new one.
	assign tick    = (step_reg == frame_seq_pkg::STEP_MAX);
	assign hr_eoc  = conv_busy_reg && tick && (filt_reg[frame_seq_pkg::PIN_MATCH] || ramp_reg == '1);
	assign hk_tick = (hk_step_reg == frame_seq_pkg::STEP_MAX);
	assign hk_eoc  = hk_busy_reg && hk_tick && (filt_reg[frame_seq_pkg::PIN_HKM] || hk_ramp_reg == '1);

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			conv_busy_reg <= 1'b0;
			ramp_reg      <= '0;
			step_reg      <= '0;
			hk_busy_reg   <= 1'b0;
			hk_ramp_reg   <= '0;
			hk_step_reg   <= '0;
			hk_enc_reg    <= 1'b0;
			hk_chan_reg   <= '0;
		end else begin
			step_reg    <= step_next(step_reg, encode);
			hk_step_reg <= step_next(hk_step_reg, clk400_rise);
			hk_enc_reg  <= clk400_rise;
			if (encode) begin
				conv_busy_reg <= 1'b1;
				ramp_reg      <= '0;
			end else if (hr_eoc) begin
				conv_busy_reg <= 1'b0;
			end else if (conv_busy_reg && tick) begin
				ramp_reg <= ramp_reg + 1'b1;
			end
			if (clk400_rise) begin
				hk_busy_reg <= 1'b1;
				hk_ramp_reg <= '0;
				hk_chan_reg <= hk_chan_reg + 1'b1;
			end else if (hk_eoc) begin
				hk_busy_reg <= 1'b0;
			end else if (hk_busy_reg && hk_tick) begin
				hk_ramp_reg <= hk_ramp_reg + 1'b1;
			end
		end
	end

	// The ramp starts at the negative end, so flipping the top bit gives two's complement.
	assign sample_signed = ramp_reg ^ frame_seq_pkg::SIGN_FLIP;
	assign hr_word   = {frame_seq_pkg::SYNC_LEVEL, gain_reg, sample_signed};
	assign hk_word   = {frame_seq_pkg::SYNC_LEVEL, 2'h0, hk_ramp_reg};
	assign link_busy = (req_reg != filt_reg[frame_seq_pkg::PIN_ACK]);
	// A word that finds the sender still busy is dropped; at the documented rates it never is.
	assign send_hr   = hr_eoc && high_rate_reg && !link_busy;
	assign send_hk   = hk_eoc && !high_rate_reg && !link_busy;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			req_reg  <= 1'b0;
			word_reg <= '0;
		end else if (send_hr || send_hk) begin
			req_reg  <= ~req_reg;
			word_reg <= send_hr ? hr_word : hk_word;
		end
	end

	word_sender u_sender (
		.link_clk (LINK_CLK),
		.rst_n    (RST_N),
		.word     (word_reg),
		.req_tgl  (req_reg),
		.ack_tgl  (ack_link),
		.buf_data (BUF_DATA),
		.buf_gate (BUF_GATE)
	);

	// Mirror servo ramps. The weights cancel when neon runs at 342 cps against 400 cps.
	assign servo_gate = (state_reg == frame_seq_pkg::ST_SETTLE) || (state_reg == frame_seq_pkg::ST_SAMPLE);
	assign pos_term = frame_seq_pkg::DRIVE_W'(pos_reg) * frame_seq_pkg::DRIVE_W'(frame_seq_pkg::SERVO_POS_WEIGHT);
	assign neg_term = frame_seq_pkg::DRIVE_W'(neg_reg) * frame_seq_pkg::DRIVE_W'(frame_seq_pkg::SERVO_NEG_WEIGHT);

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			pos_reg   <= '0;
			neg_reg   <= '0;
			drive_reg <= '0;
		end else begin
			drive_reg <= $signed(pos_term - neg_term);
			if (!servo_gate) begin
				pos_reg <= '0;
				neg_reg <= '0;
			end else begin
				if (clk400_rise)
					pos_reg <= pos_reg + 1'b1;
				if (neon_rise)
					neg_reg <= neg_reg + 1'b1;
			end
		end
	end

	assign GAIN_ATTEN    = gain_reg;
	assign ENCODE        = encode_reg;
	assign RAMP_CODE     = ramp_reg;
	assign HK_ENCODE     = hk_enc_reg;
	assign HK_RAMP_CODE  = hk_ramp_reg;
	assign HK_CHAN       = hk_chan_reg;
	assign HIGH_RATE_SEL = high_rate_reg;
	assign END_OF_FRAME  = eof_reg;
	assign MIRROR_EN     = mirror_en_reg;
	assign MIRROR_DRIVE  = drive_reg;

	default clocking cb_sys @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	property p_gain_set;
		gain_hi |=> gain_reg;
	endproperty
	a_gain_set: assert property (p_gain_set) else $error("gain flag not set above high");

	property p_gain_hold;
		(!gain_hi && !gain_lo) |=> gain_reg == $past(gain_reg);
	endproperty
	a_gain_hold: assert property (p_gain_hold) else $error("gain flag moved inside band");

	property p_settle;
		(state_reg == frame_seq_pkg::ST_SETTLE) |-> !encode ##1 !encode_reg;
	endproperty
	a_settle: assert property (p_settle) else $error("encode during settle");

	property p_settle_exit;
		(state_reg == frame_seq_pkg::ST_SETTLE && settle_done) |=> state_reg == frame_seq_pkg::ST_SAMPLE;
	endproperty
	a_settle_exit: assert property (p_settle_exit) else $error("settle did not end at count");

	property p_count;
		(state_reg == frame_seq_pkg::ST_FINISH) |-> enc_cnt_reg == frame_seq_pkg::COUNT_W'(FRAME_SAMPLES);
	endproperty
	a_count: assert property (p_count) else $error("frame ended with wrong sample count");

	property p_finish;
		(state_reg == frame_seq_pkg::ST_FINISH) |-> !mirror_en_reg ##1 (state_reg == frame_seq_pkg::ST_IDLE && eof_reg);
	endproperty
	a_finish: assert property (p_finish) else $error("frame end sequence wrong");

	property p_conv_start;
		encode |=> conv_busy_reg && ramp_reg == '0 && encode_reg;
	endproperty
	a_conv_start: assert property (p_conv_start) else $error("ramp not started by encode");

	property p_word;
		send_hr |=> word_reg[frame_seq_pkg::SYNC_POS] == frame_seq_pkg::SYNC_LEVEL
			&& word_reg[frame_seq_pkg::GAIN_POS] == $past(gain_reg)
			&& word_reg[frame_seq_pkg::SAMPLE_W-1:0] == ($past(ramp_reg) ^ frame_seq_pkg::SIGN_FLIP);
	endproperty
	a_word: assert property (p_word) else $error("data word layout wrong");

	property p_servo_clear;
		(state_reg == frame_seq_pkg::ST_FINISH) |=> pos_reg == '0 && neg_reg == '0;
	endproperty
	a_servo_clear: assert property (p_servo_clear) else $error("servo ramps not cleared");

	property p_ignore_start;
		(state_reg == frame_seq_pkg::ST_SAMPLE && start_rise) |=> state_reg != frame_seq_pkg::ST_SETTLE;
	endproperty
	a_ignore_start: assert property (p_ignore_start) else $error("start restarted a running frame");

	property p_high_rate;
		(state_reg == frame_seq_pkg::ST_IDLE && start_rise) |=> high_rate_reg;
	endproperty
	a_high_rate: assert property (p_high_rate) else $error("start did not select high rate");

	property p_hk_step;
		clk400_rise |=> hk_enc_reg && hk_chan_reg == frame_seq_pkg::HK_CHAN_W'($past(hk_chan_reg) + 1'b1);
	endproperty
	a_hk_step: assert property (p_hk_step) else $error("commutator not stepped by 400 cps");

	property p_cov_frame;
		state_reg == frame_seq_pkg::ST_FINISH;
	endproperty
	c_frame: cover property (p_cov_frame);

	property p_cov_hk;
		send_hk;
	endproperty
	c_hk: cover property (p_cov_hk);

	property p_cov_gain;
		$rose(gain_reg);
	endproperty
	c_gain: cover property (p_cov_gain);
endmodule // frame_sequencer

// ---- sim/sc_buffer_model.sv ----
// Spacecraft buffer storage model: shifts in each gated word, counts words and length faults.
// Assumes gate and data change at the rising edge of the shift clock.
`timescale 1ns/10ps
module sc_buffer_model (
	// Buffer side
	input  wire logic  link_clk,
	input  wire logic  buf_data,
	input  wire logic  buf_gate,
	// Results
	output logic [9:0] last_word = 10'h000,
	output int         n_words = 0,
	output int         n_bad = 0
);
	logic [9:0] sh_reg = 10'h000;
	int         nb = 0;
	// Falling edge sampling keeps clear of the data changes at the rising edge.
	always @(negedge link_clk) begin
		if (buf_gate) begin
			sh_reg <= {sh_reg[8:0], buf_data};
			nb <= nb + 1;
		end else if (nb != 0) begin
			last_word <= sh_reg;
			n_words <= n_words + 1;
			n_bad <= n_bad + ((nb != 10) ? 1 : 0);
			nb <= 0;
		end
	end
endmodule // sc_buffer_model

// ---- sim/interferogram_frame_sequencer_bench.sv ----
// Self-checking bench for the frame sequencer with shortened settle and frame counts.
// Assumes comparators are ideal: a ramp code at or above the held level matches.
`timescale 1ns/10ps
module interferogram_frame_sequencer_bench;
	localparam int WAVE = 3200;
	logic sys_clk = 0, link_clk = 0, rst_n = 0, start = 0, sc400 = 0, neon = 0, g_hi = 0, g_lo = 0;
	wire logic atten, encode, hk_enc, hi_sel, eof, mir_en, bdata, bgate;
	wire logic [7:0] code;
	wire logic [6:0] hk_code;
	wire logic [3:0] hk_chan;
	wire logic signed [23:0] drive;
	logic [9:0] word;
	int n_words, n_bad, err_total = 0, n_compared = 0, n_enc = 0, n_eof = 0, cyc = 0;

	always #12.5 sys_clk = ~sys_clk;
	initial begin #7; forever #80 link_clk = ~link_clk; end
	// Neon and 400 cps periods keep the nominal 400 to 342 ratio, scaled for speed.
	always #20000 neon = ~neon;
	always #17100 sc400 = ~sc400;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		n_enc <= n_enc + encode;
		n_eof <= n_eof + eof;
		if (cyc == 90000) begin
			err_total = err_total + 1;
			tally_and_finish;
		end
	end

	frame_sequencer #(.SETTLE_COUNT(4), .FRAME_SAMPLES(6)) DUT (.SYS_CLK(sys_clk), .RST_N(rst_n),
		.LINK_CLK(link_clk), .FRAME_START(start), .SC_CLK_400(sc400), .NEON_REF(neon),
		.GAIN_ABOVE_HI(g_hi), .GAIN_BELOW_LO(g_lo), .RAMP_MATCH(code >= 8'h95), .HK_MATCH(hk_code >= 7'h23),
		.GAIN_ATTEN(atten), .ENCODE(encode), .RAMP_CODE(code), .HK_ENCODE(hk_enc), .HK_RAMP_CODE(hk_code),
		.HK_CHAN(hk_chan), .HIGH_RATE_SEL(hi_sel), .END_OF_FRAME(eof), .MIRROR_EN(mir_en),
		.MIRROR_DRIVE(drive), .BUF_DATA(bdata), .BUF_GATE(bgate));
	sc_buffer_model buffer (.link_clk(link_clk), .buf_data(bdata), .buf_gate(bgate), .last_word(word),
		.n_words(n_words), .n_bad(n_bad));

	task chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", name, exp, got);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	task tally_and_finish;
		if (err_total == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task gain_hyst;
		g_hi = 1; tick(6); g_hi = 0; tick(6);
		chk("atten_set", 1, atten);
		g_lo = 1; tick(6); g_lo = 0; tick(6);
		chk("atten_clr", 0, atten);
		g_hi = 1; tick(6); g_hi = 0; tick(6);
	endtask
	task frame_run;
		int t0, w0;
		start = 1; tick(8); start = 0;
		t0 = cyc;
		while (hi_sel !== 1'b1 && cyc < t0 + 20) tick(1);
		chk("hisel_start", 1, hi_sel);
		chk("mir_en_start", 1, mir_en);
		t0 = cyc;
		while (n_enc == 0 && cyc < t0 + 6 * WAVE) tick(1);
		chk("settle_len", 1, 24'(cyc - t0 > 4 * WAVE - 100 && cyc - t0 <= 5 * WAVE + 40));
		w0 = n_words;
		start = 1; tick(8); start = 0;
		tick(WAVE);
		chk("drive_mid", 1, 24'(drive > -800 && drive < 800));
		while (n_eof == 0 && cyc < t0 + 11 * WAVE) tick(1);
		tick(2);
		chk("n_encode", 6, n_enc);
		chk("n_eof", 1, n_eof);
		chk("ramp_code", 8'h95, code);
		chk("hisel_end", 0, hi_sel);
		chk("mir_en_end", 0, mir_en);
		chk("drive_end", 0, drive);
		while (n_words - w0 < 6 && cyc < t0 + 12 * WAVE) tick(1);
		chk("n_words", 6, n_words - w0);
		chk("data_word", 10'h315, word);
		chk("word_len", 0, n_bad);
	endtask
	task hk_check;
		int t0, w;
		logic [3:0] c;
		t0 = cyc;
		w = n_words;
		while (n_words == w && cyc < t0 + 4000) tick(1);
		chk("hk_word", 10'h223, word);
		while (hk_enc !== 1'b1 && cyc < t0 + 8000) tick(1);
		tick(1);
		c = hk_chan;
		while (hk_enc !== 1'b1 && cyc < t0 + 12000) tick(1);
		tick(1);
		chk("hk_chan", 4'(c + 1), hk_chan);
	endtask

	initial begin
		tick(20);
		chk("atten_rst", 0, atten);
		chk("hisel_rst", 0, hi_sel);
		chk("gate_rst", 0, bgate);
		rst_n = 1;
		tick(4);
		gain_hyst;
		frame_run;
		hk_check;
		tally_and_finish;
	end
endmodule // interferogram_frame_sequencer_bench
